// File: core/rtsp_rx_port.v
// receive tlp streaming port with two-cycle accept-to-transfer delay
`timescale 1ns/1ps
`include "rtsp_map.vh"
module rtsp_rx_port #(
  parameter PARITY_EN = 1
) (
  input wire clk_sys,
  input wire srst,
  input wire clk_en,
  input wire src_valid,
  input wire [`RTSP_DATA_W-1:0] src_data,
  input wire src_sop,
  input wire src_eop,
  input wire [3:0] src_dwords,
  input wire src_err,
  input wire src_hdr4,
  input wire src_msg,
  input wire src_addr_bit2,
  output wire src_ready,
  input wire recv_sink_accept,
  output reg recv_beat_valid,
  output reg [`RTSP_DATA_W-1:0] recv_tlp_bus,
  output reg recv_packet_first,
  output reg recv_packet_last,
  output reg [`RTSP_EMPTY_W-1:0] recv_empty_qwords,
  output reg recv_uncorrectable_flag,
  output reg [`RTSP_PAR_W-1:0] recv_byte_odd_parity
);
  // framing states; the flush state holds the source off for one output slot
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_BODY = 2'h1;
  localparam [1:0] ST_FLUSH = 2'h2;

  reg accept_d1;
  reg pkt_shift;
  reg [31:0] carry_word;
  reg [1:0] st;
  reg [1:0] next_st;
  wire flush_pend;
  reg flush_err;
  reg pkt_err;
  wire slot_open;
  wire take;
  wire emit_flush;
  wire beat_shift;
  wire [2:0] slot_pos;
  wire [31:0] slot_word;
  wire [`RTSP_DATA_W-1:0] shifted;
  wire [31:0] spill;
  wire [4:0] out_dwords;
  wire overflow;
  wire beat_err;
  reg [`RTSP_DATA_W-1:0] next_data;
  reg next_first;
  reg next_last;
  reg [`RTSP_EMPTY_W-1:0] next_empty;
  reg next_err;

  // bit set when its byte holds an even count of ones, so nine bits are odd
  function [`RTSP_PAR_W-1:0] odd_par;
    input [`RTSP_DATA_W-1:0] d;
    integer k;
    begin
      for (k = 0; k < `RTSP_PAR_W; k = k + 1) begin
        odd_par[k] = ~(^d[k*8 +: 8]);
      end
    end
  endfunction

  // quadwords left empty in the last beat, a lone dword still fills one
  function [`RTSP_EMPTY_W-1:0] empty_of;
    input [4:0] ndw;
    reg [4:0] used_q;
    begin
      used_q = (ndw - 5'h01) >> 1;
      empty_of = 2'h3 - used_q[1:0];
    end
  endfunction

  // accept seen one cycle back; the register stage supplies the second cycle
  assign slot_open = clk_en & accept_d1;
  assign emit_flush = slot_open & flush_pend;
  // the source is held off while the spilled last dword goes out
  assign src_ready = slot_open & ~flush_pend;
  assign take = src_ready & src_valid;
  assign flush_pend = (st == ST_FLUSH);

  // pad after a 3dw header when address is qword aligned, after 4dw when not
  assign beat_shift = src_sop ?
    (src_msg ? 1'b0 : (src_hdr4 ? src_addr_bit2 : ~src_addr_bit2)) : pkt_shift;
  assign slot_pos = src_sop ? ((src_hdr4 | src_msg) ? `RTSP_HDR4_POS : `RTSP_HDR3_POS) : 3'h0;
  // the pad dword is zero; messages are never padded
  assign slot_word = src_sop ? 32'h00000000 : carry_word;

  rtsp_dword_shift #(
    .NDW(`RTSP_DWORDS)
  ) u_shift (
    .in_beat(src_data),
    .shift_en(beat_shift),
    .slot_pos(slot_pos),
    .slot_word(slot_word),
    .out_beat(shifted),
    .spill_word(spill)
  );

  assign out_dwords = {1'b0, src_dwords} + {4'h0, beat_shift};
  // a shifted full last beat leaves one dword for an extra beat
  assign overflow = src_eop & (out_dwords > 5'h08);
  // errors mark every beat of the packet from the one where they show
  assign beat_err = src_err | (pkt_err & ~src_sop);

  always @* begin
    next_st = st;
    case (st)
      ST_IDLE: begin
        // a packet may start and end in one beat
        if (take) begin
          if (overflow) begin
            next_st = ST_FLUSH;
          end else if (!src_eop) begin
            next_st = ST_BODY;
          end
        end
      end
      ST_BODY: begin
        if (take) begin
          if (overflow) begin
            next_st = ST_FLUSH;
          end else if (src_eop) begin
            next_st = ST_IDLE;
          end
        end
      end
      ST_FLUSH: begin
        if (emit_flush) begin
          next_st = ST_IDLE;
        end
      end
      default: begin
        // unused code: recover to idle
        next_st = ST_IDLE;
      end
    endcase
  end

  // outputs hold data between beats; markers fall to zero
  always @* begin
    next_data = recv_tlp_bus;
    next_first = 1'b0;
    next_last = 1'b0;
    next_empty = `RTSP_EMPTY_NONE;
    next_err = 1'b0;
    if (emit_flush) begin
      next_data = {{(`RTSP_DATA_W-32){1'b0}}, carry_word};
      next_last = 1'b1;
      next_empty = empty_of(5'h01);
      next_err = flush_err;
    end else if (take) begin
      next_data = shifted;
      next_first = src_sop;
      next_last = src_eop & ~overflow;
      if (src_eop & ~overflow) begin
        next_empty = empty_of(out_dwords);
      end
      next_err = beat_err;
    end
  end

  always @(posedge clk_sys) begin
    if (srst) begin
      accept_d1 <= 1'b0;
      recv_beat_valid <= 1'b0;
      recv_tlp_bus <= {`RTSP_DATA_W{1'b0}};
      recv_packet_first <= 1'b0;
      recv_packet_last <= 1'b0;
      recv_empty_qwords <= `RTSP_EMPTY_NONE;
      recv_uncorrectable_flag <= 1'b0;
      recv_byte_odd_parity <= {`RTSP_PAR_W{1'b0}};
      pkt_shift <= 1'b0;
      carry_word <= 32'h00000000;
      st <= ST_IDLE;
      flush_err <= 1'b0;
      pkt_err <= 1'b0;
    end else if (clk_en) begin
      // a low enable freezes the accept history too, so no slot is lost
      accept_d1 <= recv_sink_accept;
      st <= next_st;
      // valid only in a slot granted by accept two cycles earlier
      recv_beat_valid <= take | emit_flush;
      recv_tlp_bus <= next_data;
      recv_packet_first <= next_first;
      recv_packet_last <= next_last;
      recv_empty_qwords <= next_empty;
      recv_uncorrectable_flag <= next_err;
      if (PARITY_EN != 0) begin
        recv_byte_odd_parity <= odd_par(next_data);
      end
      if (emit_flush) begin
        flush_err <= 1'b0;
      end
      if (take) begin
        pkt_shift <= beat_shift & ~src_eop;
        // the spilled dword opens the next beat of a shifted packet
        carry_word <= spill;
        pkt_err <= beat_err & ~src_eop;
        if (overflow) begin
          flush_err <= beat_err;
        end
      end
    end
  end
endmodule // rtsp_rx_port

// File: core/rtsp_map.vh
// constants for the receive tlp stream port
`ifndef RTSP_MAP_VH
`define RTSP_MAP_VH
`define RTSP_DATA_W 256
`define RTSP_DWORDS 8
`define RTSP_PAR_W 32
`define RTSP_EMPTY_W 2
`define RTSP_ACCEPT_TO_TRANSFER_DELAY 2
`define RTSP_HDR3_POS 3'h3
`define RTSP_HDR4_POS 3'h4
`define RTSP_EMPTY_NONE 2'h0
`endif

// File: core/rtsp_dword_shift.v
// one-dword insertion shifter for a 256-bit beat
`timescale 1ns/1ps
module rtsp_dword_shift #(
  parameter NDW = 8
) (
  input wire [NDW*32-1:0] in_beat,
  input wire shift_en,
  input wire [2:0] slot_pos,
  input wire [31:0] slot_word,
  output wire [NDW*32-1:0] out_beat,
  output wire [31:0] spill_word
);
  genvar i;
  generate
    for (i = 0; i < NDW; i = i + 1) begin : g_dw
      if (i == 0) begin : g_first
        assign out_beat[31:0] = (shift_en && slot_pos == 3'h0) ? slot_word : in_beat[31:0];
      end else begin : g_rest
        assign out_beat[i*32+31:i*32] = !shift_en ? in_beat[i*32+31:i*32] :
          (i < slot_pos) ? in_beat[i*32+31:i*32] :
          (i == slot_pos) ? slot_word : in_beat[i*32-1:i*32-32];
      end
    end
  endgenerate
  // the top dword falls out of the beat and is carried to the next one
  assign spill_word = in_beat[NDW*32-1:NDW*32-32];
endmodule // rtsp_dword_shift

// File: test/rtsp_rx_port_sva.sv
// checker for the receive tlp port
`timescale 1ns/1ps
module rtsp_rx_port_sva (
  input wire clk_sys,
  input wire srst,
  input wire src_valid,
  input wire src_ready,
  input wire recv_sink_accept,
  input wire recv_beat_valid,
  input wire [255:0] recv_tlp_bus,
  input wire recv_packet_first,
  input wire recv_packet_last,
  input wire [1:0] recv_empty_qwords,
  input wire recv_uncorrectable_flag,
  input wire [31:0] recv_byte_odd_parity
);
  wire v = recv_beat_valid;
  wire a = recv_sink_accept;
  wire l = recv_packet_last;
  wire f = recv_uncorrectable_flag;
  reg inp = 1'b0;
  reg bad = 1'b0;
  wire [31:0] par_exp;
  genvar k;
  generate
    for (k = 0; k < 32; k = k + 1) begin : g_par
      assign par_exp[k] = ~^recv_tlp_bus[k*8 +: 8];
    end
  endgenerate
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  // packet state, so markers are judged per beat
  always @(posedge clk_sys) begin
    if (srst) begin
      inp <= 1'b0;
      bad <= 1'b0;
    end else if (v) begin
      inp <= !l;
      bad <= f && !l;
    end
  end
  AST_LAT: assert property (v |-> $past(a, 2)) else $error("early valid");
  AST_DROP: assert property ($fell(a) |-> ##2 !v) else $error("valid kept");
  AST_SRC: assert property (src_ready |-> $past(a)) else $error("early take");
  AST_OUT: assert property (src_valid && src_ready |=> v) else $error("beat lost");
  AST_SOP: assert property (v |-> recv_packet_first == !inp) else $error("bad first");
  AST_EMP: assert property (v && !l |-> recv_empty_qwords == 2'h0) else $error("bad empty");
  AST_ERR: assert property (v && bad |-> f) else $error("flag lost");
  AST_PAR: assert property (v |-> recv_byte_odd_parity == par_exp)
    else $error("bad parity");
  cover property (v && recv_packet_first && l);
  cover property (v && l && recv_empty_qwords == 2'h3);
  cover property (v && f);
  cover property (v && l && recv_empty_qwords == 2'h1);
endmodule // rtsp_rx_port_sva
bind rtsp_rx_port rtsp_rx_port_sva u_sva (.*);

// File: test/rtsp_sink_model.sv
// user-side sink that takes every beat and can throttle
`timescale 1ns/1ps
module rtsp_sink_model (
  input wire clk_sys,
  input wire slow,
  input wire recv_beat_valid,
  input wire [255:0] recv_tlp_bus,
  input wire [4:0] recv_tag,
  output reg recv_sink_accept
);
  reg [255:0] dat [0:7];
  reg [4:0] tag [0:7];
  integer n = 0;
  initial recv_sink_accept = 1'b0;
  // slow mode drops accept every other cycle
  always @(negedge clk_sys) recv_sink_accept <= slow ? !recv_sink_accept : 1'b1;
  // beats in flight after accept falls cannot be refused
  always @(posedge clk_sys) begin
    if (recv_beat_valid) begin
      dat[n % 8] <= recv_tlp_bus;
      tag[n % 8] <= recv_tag;
      n <= n + 1;
    end
  end
endmodule // rtsp_sink_model

// File: test/tb_pcie_rx_tlp_stream_port.sv
// bench for the receive tlp stream port
`timescale 1ns/1ps
`define CK(a, b) begin checked++; if ((a) !== (b)) begin failures++; \
  $display("CHECK FAILED %0t %h %h", $time, a, b); end end
module tb_pcie_rx_tlp_stream_port;
  localparam [255:0] PAT = {32'h8, 32'h7, 32'h6, 32'h5, 32'h4, 32'h3, 32'h2, 32'h1};
  reg clk_sys = 1'b0;
  reg srst = 1'b1;
  reg slow = 1'b0;
  reg sv = 1'b0;
  reg sop = 1'b0;
  reg eop = 1'b0;
  reg err = 1'b0;
  reg msg = 1'b0;
  reg a2 = 1'b0;
  reg h4 = 1'b0;
  reg [255:0] sd = 256'h0;
  reg [3:0] dw = 4'h1;
  wire rdy, acc, vld, first, last, flag;
  wire [255:0] bus;
  wire [1:0] emp;
  integer failures = 0;
  integer checked = 0;
  integer b;
  always #50 clk_sys = ~clk_sys;
  rtsp_rx_port u_dut (.clk_sys(clk_sys), .srst(srst), .clk_en(1'b1), .src_valid(sv),
    .src_data(sd), .src_sop(sop), .src_eop(eop), .src_dwords(dw), .src_err(err),
    .src_hdr4(h4), .src_msg(msg), .src_addr_bit2(a2), .src_ready(rdy),
    .recv_sink_accept(acc), .recv_beat_valid(vld), .recv_tlp_bus(bus),
    .recv_packet_first(first), .recv_packet_last(last), .recv_empty_qwords(emp),
    .recv_uncorrectable_flag(flag), .recv_byte_odd_parity());
  rtsp_sink_model u_sink (.clk_sys(clk_sys), .slow(slow), .recv_beat_valid(vld),
    .recv_tlp_bus(bus), .recv_tag({first, last, emp, flag}), .recv_sink_accept(acc));
  // valid stays up between beats, so back to back needs no edge gap
  task beat(input [255:0] d, input s, input e, input [3:0] w);
    begin
      sd = d;
      sop = s;
      eop = e;
      dw = w;
      sv = 1'b1;
      repeat (40) if (!rdy) @(negedge clk_sys);
      if (!rdy) failures++;
      @(negedge clk_sys);
    end
  endtask
  task idle;
    begin
      sv = 1'b0;
      repeat (8) @(negedge clk_sys);
    end
  endtask
  task t_plain;
    begin
      a2 = 1'b1;
      b = u_sink.n;
      beat(PAT, 1'b1, 1'b1, 4'h4);
      idle;
      `CK(u_sink.dat[b % 8], PAT)
      `CK(u_sink.tag[b % 8], 5'h1C)
    end
  endtask
  task t_pad;
    begin
      a2 = 1'b0;
      err = 1'b1;
      b = u_sink.n;
      beat(PAT, 1'b1, 1'b0, 4'h8);
      err = 1'b0;
      beat(~PAT, 1'b0, 1'b1, 4'h8);
      idle;
      `CK(u_sink.dat[b % 8], {PAT[223:96], 32'h0, PAT[95:0]})
      `CK(u_sink.dat[(b + 1) % 8], {~PAT[223:0], PAT[255:224]})
      `CK(u_sink.dat[(b + 2) % 8][31:0], ~PAT[255:224])
      `CK({u_sink.tag[b % 8], u_sink.tag[(b + 1) % 8]}, {5'h11, 5'h01})
      `CK(u_sink.tag[(b + 2) % 8], 5'h0F)
    end
  endtask
  task t_hdr4;
    begin
      h4 = 1'b1;
      a2 = 1'b1;
      b = u_sink.n;
      beat(PAT, 1'b1, 1'b0, 4'h8);
      beat(~PAT, 1'b0, 1'b1, 4'h5);
      a2 = 1'b0;
      beat(PAT, 1'b1, 1'b1, 4'h8);
      idle;
      `CK(u_sink.dat[b % 8], {PAT[223:128], 32'h0, PAT[127:0]})
      `CK(u_sink.dat[(b + 1) % 8], {~PAT[223:0], PAT[255:224]})
      `CK(u_sink.dat[(b + 2) % 8], PAT)
      `CK({u_sink.tag[b % 8], u_sink.tag[(b + 1) % 8], u_sink.tag[(b + 2) % 8]}, 15'h4158)
      `CK(u_sink.n, b + 3)
      h4 = 1'b0;
    end
  endtask
  task t_msg;
    begin
      msg = 1'b1;
      slow = 1'b1;
      b = u_sink.n;
      beat(PAT, 1'b1, 1'b0, 4'h8);
      beat(~PAT, 1'b0, 1'b0, 4'h8);
      beat(PAT, 1'b0, 1'b1, 4'h8);
      idle;
      `CK(u_sink.dat[(b + 1) % 8], ~PAT)
      `CK(u_sink.tag[(b + 2) % 8], 5'h08)
      `CK(u_sink.n, b + 3)
    end
  endtask
  task wrap_up;
    begin
      $display("failures=%0d checked=%0d", failures, checked);
      if (failures == 0 && checked > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask
  initial begin
    repeat (10) @(negedge clk_sys);
    srst = 1'b0;
    t_plain;
    t_pad;
    t_hdr4;
    t_msg;
    wrap_up;
  end
  // the four scenarios need well under 100 cycles
  initial begin
    #100000;
    failures++;
    wrap_up;
  end
endmodule // tb_pcie_rx_tlp_stream_port
